// >>> rtl/resb_pkg.sv
// Package: constants for the receive error, link status and bit framing register bank.
// Assumes: one 40 MHz clock and 32-bit AHB-Lite register words.
package resb_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_ERROR = 8'h0A;
	localparam logic [7:0] IDX_STATUS = 8'h0B;
	localparam logic [7:0] IDX_FRAMING = 8'h0C;
	localparam logic [7:0] IDX_COLL = 8'h0D;
	localparam logic [7:0] IDX_EMD_CTRL = 8'h10;
	localparam logic [9:0] ADDR_ERROR = {IDX_ERROR, 2'b00};
	localparam logic [9:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
	localparam logic [9:0] ADDR_FRAMING = {IDX_FRAMING, 2'b00};
	localparam logic [9:0] ADDR_COLL = {IDX_COLL, 2'b00};
	localparam logic [9:0] ADDR_EMD_CTRL = {IDX_EMD_CTRL, 2'b00};
	// Error flag positions
	localparam int ERR_SHORT = 4;
	localparam int ERR_EMPTY = 3;
	localparam int ERR_COLL = 2;
	localparam int ERR_PROT = 1;
	localparam int ERR_INTEG = 0;
	// Status, framing and collision field positions
	localparam int ST_CIPHER = 5;
	localparam int FR_KEEP = 7;
	localparam int FR_ALIGN_LO = 4;
	localparam int FR_COLLISION_AS_INTEGRITY_ERROR = 3;
	localparam int FR_LAST_LO = 0;
	localparam int COLL_VALID = 7;
	// Reset values
	localparam logic [7:0] FRAMING_RST = 8'h00;
	localparam logic EMD_RST = 1'b0;
	// Frame limits
	localparam logic [6:0] MIN_FRAME_BITS = 7'h04;
	localparam logic [1:0] EMD_MIN_BYTES = 2'h3;
	localparam logic [7:0] COLL_RANGE = 8'h40;
	// Combined transmit and receive state
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_TX_WAIT = 3'b001,
		ST_TRANSMIT = 3'b011,
		ST_RX_WAIT = 3'b101,
		ST_WAIT_DATA = 3'b110,
		ST_RECEIVE = 3'b111
	} resb_state_e;
endpackage

// >>> rtl/resb_core.sv
// Receive error flags, link state, cipher status and bit framing with an AHB-Lite slave.
// Assumes: command, transmitter and receive decoder strobes come from logic on core_clk.
`timescale 1ns/100ps
module resb_core (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic cmd_transmit,
	input wire logic cmd_receive,
	input wire logic cmd_transceive,
	input wire logic cmd_stop,
	input wire logic cipher_auth_ok,
	input wire logic fifo_empty,
	input wire logic tx_done,
	input wire logic rx_wait_done,
	input wire logic rx_sof,
	input wire logic rx_bit_valid,
	input wire logic rx_bit,
	input wire logic rx_bit_collision,
	input wire logic rx_bit_in_eof,
	input wire logic rx_end,
	input wire logic rx_stop_bit_err,
	input wire logic rx_sof_eof_err,
	input wire logic rx_byte_count_err,
	input wire logic rx_parity_err,
	input wire logic rx_crc_err,
	output logic fifo_wr_valid,
	output logic [7:0] fifo_wr_data,
	output logic frame_discard,
	output logic receive_interrupt,
	output logic decoder_enable,
	output logic [2:0] link_state,
	output logic cipher_active
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////////////////////
	// Bus slave
	logic wr_pend_reg, wr_pend_next;
	logic [9:0] wr_addr_reg, wr_addr_next;
	logic [31:0] hrdata_reg, hrdata_next;
	logic addr_phase;
	logic sw_wr;
	logic [7:0] sw_data;

	// Register bank state
	resb_pkg::resb_state_e state_reg, state_next;
	logic [4:0] err_reg, err_next;
	logic cipher_reg, cipher_next;
	logic keep_reg, keep_next;
	logic [2:0] align_reg, align_next;
	logic collision_as_integrity_error_reg, collision_as_integrity_error_next;
	logic [2:0] last_reg, last_next;
	logic emd_reg, emd_next;
	logic [6:0] cpos_reg, cpos_next;
	logic cvalid_reg, cvalid_next;
	logic trx_reg, trx_next;
	logic [2:0] pos_reg, pos_next;
	logic [6:0] bits_reg, bits_next;
	logic [1:0] bytes_reg, bytes_next;
	logic [7:0] acc_reg, acc_next;
	logic cseen_reg, cseen_next;
	logic wr_reg, wr_next;
	logic [7:0] wdata_reg, wdata_next;
	logic disc_reg, disc_next;
	logic irq_reg, irq_next;
	logic dec_reg, dec_next;
	logic prot_evt;
	logic [7:0] cpos_sum;

	assign addr_phase = hsel && htrans[1] && hready;
	assign sw_wr = wr_pend_reg;
	assign sw_data = hwdata[7:0];

	always_comb begin
		wr_pend_next = addr_phase && hwrite;
		wr_addr_next = haddr[9:0];
		hrdata_next = hrdata_reg;
		if (addr_phase && !hwrite) begin
			case (haddr[9:0])
				resb_pkg::ADDR_ERROR: hrdata_next = {27'h0, err_reg};
				resb_pkg::ADDR_STATUS: hrdata_next = {26'h0, cipher_reg, 2'b00, state_reg};
				resb_pkg::ADDR_FRAMING: hrdata_next = {24'h000000, keep_reg, align_reg, collision_as_integrity_error_reg, last_reg};
				resb_pkg::ADDR_COLL: hrdata_next = {24'h000000, cvalid_reg, cpos_reg};
				resb_pkg::ADDR_EMD_CTRL: hrdata_next = {31'h0, emd_reg};
				default: hrdata_next = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 10'h000;
			hrdata_reg <= 32'h00000000;
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end else begin
			wr_pend_reg <= wr_pend_next;
			wr_addr_reg <= wr_addr_next;
			hrdata_reg <= hrdata_next;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	assign hrdata = hrdata_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Link state, receive framing and error flags
	assign prot_evt = rx_stop_bit_err || rx_sof_eof_err || rx_byte_count_err;
	assign cpos_sum = {5'h00, align_reg} + {1'b0, bits_reg};

	always_comb begin
		state_next = state_reg;
		err_next = err_reg;
		cipher_next = cipher_reg;
		keep_next = keep_reg;
		align_next = align_reg;
		collision_as_integrity_error_next = collision_as_integrity_error_reg;
		last_next = last_reg;
		emd_next = emd_reg;
		cpos_next = cpos_reg;
		cvalid_next = cvalid_reg;
		trx_next = trx_reg;
		pos_next = pos_reg;
		bits_next = bits_reg;
		bytes_next = bytes_reg;
		acc_next = acc_reg;
		cseen_next = cseen_reg;
		wr_next = 1'b0;
		wdata_next = wdata_reg;
		disc_next = 1'b0;
		irq_next = 1'b0;
		// Software writes first so hardware events win
		if (sw_wr) begin
			case (wr_addr_reg)
				resb_pkg::ADDR_STATUS: begin
					if (!sw_data[resb_pkg::ST_CIPHER])
						cipher_next = 1'b0;
				end
				resb_pkg::ADDR_FRAMING: begin
					keep_next = sw_data[resb_pkg::FR_KEEP];
					align_next = sw_data[resb_pkg::FR_ALIGN_LO +: 3];
					collision_as_integrity_error_next = sw_data[resb_pkg::FR_COLLISION_AS_INTEGRITY_ERROR];
					last_next = sw_data[resb_pkg::FR_LAST_LO +: 3];
				end
				resb_pkg::ADDR_EMD_CTRL: emd_next = sw_data[0];
				default: ;
			endcase
		end
		if (cipher_auth_ok)
			cipher_next = 1'b1;
		case (state_reg)
			resb_pkg::ST_IDLE: begin
				if (cmd_transmit || cmd_transceive) begin
					trx_next = cmd_transceive;
					state_next = resb_pkg::ST_TX_WAIT;
				end else if (cmd_receive) begin
					trx_next = 1'b0;
					err_next[resb_pkg::ERR_SHORT] = 1'b0;
					err_next[resb_pkg::ERR_COLL] = 1'b0;
					err_next[resb_pkg::ERR_PROT] = 1'b0;
					err_next[resb_pkg::ERR_INTEG] = 1'b0;
					cvalid_next = 1'b0;
					state_next = resb_pkg::ST_RX_WAIT;
				end
			end
			resb_pkg::ST_TX_WAIT: begin
				if (fifo_empty) begin
					err_next[resb_pkg::ERR_EMPTY] = 1'b1;
					state_next = resb_pkg::ST_IDLE;
				end else begin
					err_next[resb_pkg::ERR_EMPTY] = 1'b0;
					state_next = resb_pkg::ST_TRANSMIT;
				end
			end
			resb_pkg::ST_TRANSMIT: begin
				if (tx_done)
					state_next = trx_reg ? resb_pkg::ST_RX_WAIT : resb_pkg::ST_IDLE;
			end
			resb_pkg::ST_RX_WAIT: begin
				if (rx_wait_done) begin
					if (trx_reg) begin
						err_next[resb_pkg::ERR_SHORT] = 1'b0;
						err_next[resb_pkg::ERR_COLL] = 1'b0;
						err_next[resb_pkg::ERR_PROT] = 1'b0;
						err_next[resb_pkg::ERR_INTEG] = 1'b0;
						cvalid_next = 1'b0;
					end
					state_next = resb_pkg::ST_WAIT_DATA;
				end
			end
			resb_pkg::ST_WAIT_DATA: begin
				if (rx_sof) begin
					last_next = 3'h0;
					pos_next = align_reg;
					bits_next = 7'h00;
					bytes_next = 2'h0;
					acc_next = 8'h00;
					cseen_next = 1'b0;
					state_next = resb_pkg::ST_RECEIVE;
				end
			end
			resb_pkg::ST_RECEIVE: begin
				if (rx_parity_err || rx_crc_err)
					err_next[resb_pkg::ERR_INTEG] = 1'b1;
				if (rx_bit_valid && !rx_bit_in_eof) begin
					if (rx_bit_collision && !cseen_reg) begin
						cseen_next = 1'b1;
						err_next[resb_pkg::ERR_COLL] = 1'b1;
						if (collision_as_integrity_error_reg)
							err_next[resb_pkg::ERR_INTEG] = 1'b1;
						cpos_next = cpos_sum[6:0];
						cvalid_next = cpos_sum < resb_pkg::COLL_RANGE;
					end
					acc_next[pos_reg] = (cseen_reg && !keep_reg) ? 1'b0 : rx_bit;
					pos_next = pos_reg + 3'h1;
					if (bits_reg != 7'h7F)
						bits_next = bits_reg + 7'h01;
					if (pos_reg == 3'h7 && !prot_evt) begin
						wr_next = 1'b1;
						wdata_next = acc_next;
						acc_next = 8'h00;
						if (bytes_reg != resb_pkg::EMD_MIN_BYTES)
							bytes_next = bytes_reg + 2'h1;
					end
				end
				if (prot_evt) begin
					err_next[resb_pkg::ERR_PROT] = 1'b1;
					irq_next = 1'b1;
					state_next = resb_pkg::ST_IDLE;
				end else if (rx_end) begin
					if (bits_reg < resb_pkg::MIN_FRAME_BITS) begin
						err_next[resb_pkg::ERR_SHORT] = 1'b1;
						disc_next = 1'b1;
						state_next = resb_pkg::ST_WAIT_DATA;
					end else if (emd_reg && bytes_reg < resb_pkg::EMD_MIN_BYTES) begin
						disc_next = 1'b1;
						state_next = resb_pkg::ST_WAIT_DATA;
					end else begin
						if (align_reg != 3'h0)
							last_next = pos_reg;
						if (pos_reg != 3'h0) begin
							wr_next = 1'b1;
							wdata_next = acc_reg;
						end
						irq_next = 1'b1;
						state_next = resb_pkg::ST_IDLE;
					end
				end
			end
			default: state_next = resb_pkg::ST_IDLE;
		endcase
		if (cmd_stop)
			state_next = resb_pkg::ST_IDLE;
		// Decoder stays on while waiting for or receiving a frame
		dec_next = (state_next == resb_pkg::ST_WAIT_DATA) || (state_next == resb_pkg::ST_RECEIVE);
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_reg <= resb_pkg::ST_IDLE;
			err_reg <= 5'h00;
			cipher_reg <= 1'b0;
			keep_reg <= resb_pkg::FRAMING_RST[resb_pkg::FR_KEEP];
			align_reg <= resb_pkg::FRAMING_RST[resb_pkg::FR_ALIGN_LO +: 3];
			collision_as_integrity_error_reg <= resb_pkg::FRAMING_RST[resb_pkg::FR_COLLISION_AS_INTEGRITY_ERROR];
			last_reg <= resb_pkg::FRAMING_RST[resb_pkg::FR_LAST_LO +: 3];
			emd_reg <= resb_pkg::EMD_RST;
			cpos_reg <= 7'h00;
			cvalid_reg <= 1'b0;
			trx_reg <= 1'b0;
			pos_reg <= 3'h0;
			bits_reg <= 7'h00;
			bytes_reg <= 2'h0;
			acc_reg <= 8'h00;
			cseen_reg <= 1'b0;
			wr_reg <= 1'b0;
			wdata_reg <= 8'h00;
			disc_reg <= 1'b0;
			irq_reg <= 1'b0;
			dec_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			err_reg <= err_next;
			cipher_reg <= cipher_next;
			keep_reg <= keep_next;
			align_reg <= align_next;
			collision_as_integrity_error_reg <= collision_as_integrity_error_next;
			last_reg <= last_next;
			emd_reg <= emd_next;
			cpos_reg <= cpos_next;
			cvalid_reg <= cvalid_next;
			trx_reg <= trx_next;
			pos_reg <= pos_next;
			bits_reg <= bits_next;
			bytes_reg <= bytes_next;
			acc_reg <= acc_next;
			cseen_reg <= cseen_next;
			wr_reg <= wr_next;
			wdata_reg <= wdata_next;
			disc_reg <= disc_next;
			irq_reg <= irq_next;
			dec_reg <= dec_next;
		end
	end

	assign fifo_wr_valid = wr_reg;
	assign fifo_wr_data = wdata_reg;
	assign frame_discard = disc_reg;
	assign receive_interrupt = irq_reg;
	assign decoder_enable = dec_reg;
	assign link_state = state_reg;
	assign cipher_active = cipher_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	sequence short_end_s;
		state_reg == resb_pkg::ST_RECEIVE && rx_end && !prot_evt && !cmd_stop && bits_reg < resb_pkg::MIN_FRAME_BITS;
	endsequence
	sequence emd_end_s;
		state_reg == resb_pkg::ST_RECEIVE && rx_end && !prot_evt && !cmd_stop && emd_reg
			&& bits_reg >= resb_pkg::MIN_FRAME_BITS && bytes_reg < resb_pkg::EMD_MIN_BYTES;
	endsequence

	chk_short_flag_set: assert property (short_end_s |=> err_reg[resb_pkg::ERR_SHORT])
		else $error("short frame not flagged");
	chk_short_silent_drop: assert property (short_end_s |=> !receive_interrupt && frame_discard
		&& state_reg == resb_pkg::ST_WAIT_DATA && decoder_enable)
		else $error("short frame not silently discarded");
	chk_emd_silent_drop: assert property (emd_end_s |=> !receive_interrupt && frame_discard
		&& err_reg[resb_pkg::ERR_SHORT] == $past(err_reg[resb_pkg::ERR_SHORT]))
		else $error("suppressed frame not discarded");
	chk_receive_clears_flags: assert property (state_reg == resb_pkg::ST_IDLE && cmd_receive && !cmd_transmit
		&& !cmd_transceive |=> err_reg[resb_pkg::ERR_PROT:resb_pkg::ERR_INTEG] == 2'b00
		&& !err_reg[resb_pkg::ERR_SHORT])
		else $error("receive start left errors set");
	chk_empty_send_flag: assert property (state_reg == resb_pkg::ST_TX_WAIT && fifo_empty
		|=> err_reg[resb_pkg::ERR_EMPTY] && state_reg != resb_pkg::ST_TRANSMIT)
		else $error("empty send not flagged");
	chk_eof_coll_ignored: assert property (state_reg == resb_pkg::ST_RECEIVE && rx_bit_valid && rx_bit_in_eof
		&& !err_reg[resb_pkg::ERR_COLL] |=> !err_reg[resb_pkg::ERR_COLL])
		else $error("collision in EOF flagged");
	chk_prot_stops_rx: assert property (state_reg == resb_pkg::ST_RECEIVE && prot_evt && !cmd_stop
		|=> err_reg[resb_pkg::ERR_PROT] && state_reg == resb_pkg::ST_IDLE && !fifo_wr_valid)
		else $error("protocol error did not stop reception");
	chk_integ_continues: assert property (state_reg == resb_pkg::ST_RECEIVE && rx_parity_err && !prot_evt
		&& !rx_end && !cmd_stop |=> err_reg[resb_pkg::ERR_INTEG] && state_reg == resb_pkg::ST_RECEIVE)
		else $error("integrity error stopped reception");
	chk_cipher_set_cause: assert property ($rose(cipher_active) |-> $past(cipher_auth_ok))
		else $error("cipher set without authentication");
	chk_state_code_used: assert property (link_state != 3'b100 && link_state != 3'b010)
		else $error("unused link state code");
	chk_last_bits_clear: assert property (state_reg == resb_pkg::ST_WAIT_DATA && rx_sof && !cmd_stop
		|=> last_reg == 3'h0 && pos_reg == $past(align_reg))
		else $error("reception start did not reset framing");
endmodule // resb_core

// >>> tb/resb_card_model.sv
// Card side model: drives the receive decoder strobes for one frame at a time.
// Assumes: the bench calls frame; every change lands just after a core_clk rising edge.
`timescale 1ns/100ps
module resb_card_model (
	input wire logic core_clk,
	output logic rx_sof,
	output logic rx_bit_valid,
	output logic rx_bit,
	output logic rx_bit_collision,
	output logic rx_bit_in_eof,
	output logic rx_end,
	output logic [4:0] rx_err
);
	initial begin
		{rx_sof, rx_bit_valid, rx_bit, rx_bit_collision, rx_bit_in_eof, rx_end, rx_err} = '0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Frame: SOF, n data bits, optional collided EOF bit, end only if ek is 3 or more; fault ek at bit ea
	task automatic frame(input int n, input logic [63:0] d, input int ca, input int ea, input int ek, input bit ec);
		@(posedge core_clk) rx_sof <= 1'b1;
		@(posedge core_clk) rx_sof <= 1'b0;
		for (int i = 0; i < n; i++) begin
			@(posedge core_clk) rx_bit_valid <= 1'b1;
			rx_bit <= d[i];
			rx_bit_collision <= (i == ca);
			rx_err <= (i == ea) ? 5'h01 << ek : 5'h00;
		end
		@(posedge core_clk) rx_bit_valid <= ec;
		rx_bit_in_eof <= ec;
		rx_bit_collision <= ec;
		rx_bit <= ~rx_bit;
		rx_err <= 5'h00;
		@(posedge core_clk) rx_bit_valid <= 1'b0;
		rx_bit_in_eof <= 1'b0;
		rx_bit_collision <= 1'b0;
		rx_end <= (ek >= 3);
		@(posedge core_clk) rx_end <= 1'b0;
	endtask
endmodule // resb_card_model

// >>> tb/resb_core_test.sv
// Bench for the receive error, status and framing bank: AHB-Lite master and card model.
// Assumes: one 40 MHz clock, synchronous reset held for 10 cycles.
`timescale 1ns/100ps
module resb_core_test;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0, hwrite = 1'b0, fifo_empty = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, r;
	logic [6:0] st = 7'h00;
	logic hreadyout, hresp, fifo_wr_valid, frame_discard, receive_interrupt, decoder_enable, cipher_active;
	logic [7:0] fifo_wr_data;
	logic [2:0] link_state;
	logic rx_sof, rx_bit_valid, rx_bit, rx_bit_collision, rx_bit_in_eof, rx_end;
	logic [4:0] rx_err;
	logic [63:0] d;
	logic [7:0] wr_q[$];
	int mismatches = 0, checks_done = 0, cyc = 0, irqs = 0, discs = 0, seed = 32'h17DB8016;
	int a, n, ca, kp, nb;
	resb_core i_resb_core (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .cmd_transmit(st[0]), .cmd_receive(st[1]),
		.cmd_transceive(st[2]), .cmd_stop(st[3]), .cipher_auth_ok(st[4]), .fifo_empty(fifo_empty),
		.tx_done(st[5]), .rx_wait_done(st[6]), .rx_sof(rx_sof), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
		.rx_bit_collision(rx_bit_collision), .rx_bit_in_eof(rx_bit_in_eof), .rx_end(rx_end),
		.rx_stop_bit_err(rx_err[0]), .rx_sof_eof_err(rx_err[1]), .rx_byte_count_err(rx_err[2]),
		.rx_parity_err(rx_err[3]), .rx_crc_err(rx_err[4]), .fifo_wr_valid(fifo_wr_valid),
		.fifo_wr_data(fifo_wr_data), .frame_discard(frame_discard), .receive_interrupt(receive_interrupt),
		.decoder_enable(decoder_enable), .link_state(link_state), .cipher_active(cipher_active));
	resb_card_model i_resb_card_model (.core_clk(core_clk), .rx_sof(rx_sof), .rx_bit_valid(rx_bit_valid),
		.rx_bit(rx_bit), .rx_bit_collision(rx_bit_collision), .rx_bit_in_eof(rx_bit_in_eof),
		.rx_end(rx_end), .rx_err(rx_err));
	always #12.5 core_clk = ~core_clk;
	////////////////////////////////////////////////////////////////////////////////
	// Monitor and timeout
	always @(posedge core_clk) begin
		cyc++;
		if (fifo_wr_valid === 1'b1) wr_q.push_back(fifo_wr_data);
		irqs += (receive_interrupt === 1'b1);
		discs += (frame_discard === 1'b1);
		if (cyc == 20000) begin
			mismatches++;
			results;
		end
	end
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task ahb(input logic wr, input logic [9:0] ad, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {22'h0, ad};
		hwrite <= wr;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task pulse(input int b);
		@(posedge core_clk) st[b] <= 1'b1;
		@(posedge core_clk) st[b] <= 1'b0;
		#1;
	endtask
	function automatic logic [7:0] exp_byte(int al, logic [63:0] dd, int nn, int cc, int kk, int k);
		logic [7:0] v;
		for (int j = 0; j < 8; j++) begin
			int i = 8 * k + j - al;
			v[j] = (i >= 0 && i < nn) ? dd[i] & (kk != 0 || cc < 0 || i <= cc) : 1'b0;
		end
		return v;
	endfunction
	task rxrun(input int al, kk, nc, nn, input logic [63:0] dd, input int cc, ea, ek, input bit ec);
		ahb(1'b1, resb_pkg::ADDR_FRAMING, {24'h0, kk[0], al[2:0], nc[0], 3'h0});
		fifo_empty <= 1'b0;
		pulse(2);
		chk("state tx wait", link_state, resb_pkg::ST_TX_WAIT);
		@(posedge core_clk);
		#1;
		chk("state tx", link_state, resb_pkg::ST_TRANSMIT);
		pulse(5);
		chk("state rx wait", link_state, resb_pkg::ST_RX_WAIT);
		pulse(6);
		chk("wait data", {decoder_enable, link_state}, {1'b1, resb_pkg::ST_WAIT_DATA});
		ahb(1'b0, resb_pkg::ADDR_ERROR, 32'h0);
		chk("flags cleared", rd & 32'h17, 32'h0);
		wr_q.delete();
		irqs = 0;
		discs = 0;
		i_resb_card_model.frame(nn, dd, cc, ea, ek, ec);
		repeat (3) @(posedge core_clk);
		#1;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		for (int i = 0; i < 6; i++) begin
			ahb(1'b0, 10'h28 + 10'(4 * i), 32'h0);
			chk("reset value", rd, 32'h0);
		end
		r = $random(seed) & 32'hF8;
		ahb(1'b1, resb_pkg::ADDR_FRAMING, r);
		ahb(1'b0, resb_pkg::ADDR_FRAMING, 32'h0);
		chk("framing", rd, r);
		$display("test registers done");
		fifo_empty <= 1'b1;
		pulse(0);
		repeat (2) @(posedge core_clk);
		ahb(1'b0, resb_pkg::ADDR_ERROR, 32'h0);
		chk("empty send", rd[3], 1'b1);
		pulse(3);
		chk("stop idle", link_state, resb_pkg::ST_IDLE);
		fifo_empty <= 1'b0;
		pulse(1);
		pulse(6);
		irqs = 0;
		discs = 0;
		i_resb_card_model.frame(3, 64'h5, -1, -1, 3, 0);
		repeat (3) @(posedge core_clk);
		#1;
		chk("short drop", {discs[1:0], irqs[1:0], decoder_enable, link_state}, {4'h4, 1'b1, 3'h6});
		ahb(1'b0, resb_pkg::ADDR_ERROR, 32'h0);
		chk("short flag", rd[4], 1'b1);
		pulse(3);
		$display("test short frame done");
		for (int t = 0; t < 4; t++) begin
			a = (t == 0) ? 0 : 1 + {$random(seed)} % 7;
			n = (t == 0) ? 16 : 9 + {$random(seed)} % 40;
			ca = (t == 0) ? -1 : {$random(seed)} % n;
			kp = $random(seed) & 1;
			d = {$random(seed), $random(seed)};
			rxrun(a, kp, t & 1, n, d, ca, -1, 3, 0);
			nb = (a + n + 7) / 8;
			chk("byte count", wr_q.size(), nb);
			for (int k = 0; k < nb && k < wr_q.size(); k++)
				chk("rx byte", wr_q[k], exp_byte(a, d, n, ca, kp, k));
			chk("frame end", {irqs[1:0], link_state}, {2'h1, 3'h0});
			ahb(1'b0, resb_pkg::ADDR_FRAMING, 32'h0);
			chk("last bits", rd[2:0], (a == 0) ? 3'h0 : 3'((a + n) % 8));
			ahb(1'b0, resb_pkg::ADDR_ERROR, 32'h0);
			chk("coll flags", rd[2:0], (ca < 0) ? 3'h0 : {2'b10, t[0]});
			ahb(1'b0, resb_pkg::ADDR_COLL, 32'h0);
			chk("coll pos", rd, (ca < 0) ? 32'h0 : {24'h0, 1'b1, 7'(a + ca)});
		end
		$display("test frames done");
		rxrun(0, 1, 0, 8, d, -1, -1, 3, 1);
		ahb(1'b0, resb_pkg::ADDR_ERROR, 32'h0);
		chk("eof coll", rd[2:0], 3'h0);
		rxrun(0, 1, 0, 16, d, -1, 4, 3, 0);
		chk("integ bytes", wr_q.size(), 2);
		ahb(1'b0, resb_pkg::ADDR_ERROR, 32'h0);
		chk("integ flag", rd[1:0], 2'h1);
		rxrun(0, 1, 0, 12, d, -1, 11, 0, 0);
		chk("prot bytes", wr_q.size(), 1);
		chk("prot stop", {irqs[1:0], link_state}, {2'h1, 3'h0});
		ahb(1'b0, resb_pkg::ADDR_ERROR, 32'h0);
		chk("prot flag", rd[1], 1'b1);
		ahb(1'b1, resb_pkg::ADDR_EMD_CTRL, 32'h1);
		rxrun(0, 1, 0, 16, d, -1, -1, 3, 0);
		chk("emd drop", {discs[1:0], irqs[1:0]}, 4'h4);
		ahb(1'b0, resb_pkg::ADDR_ERROR, 32'h0);
		chk("emd no flag", rd[4], 1'b0);
		ahb(1'b1, resb_pkg::ADDR_EMD_CTRL, 32'h0);
		pulse(3);
		$display("test faults done");
		pulse(4);
		ahb(1'b1, resb_pkg::ADDR_STATUS, 32'h20);
		ahb(1'b0, resb_pkg::ADDR_STATUS, 32'h0);
		chk("cipher on", {rd[5], cipher_active}, 2'h3);
		ahb(1'b1, resb_pkg::ADDR_STATUS, 32'h0);
		ahb(1'b1, resb_pkg::ADDR_STATUS, 32'h20);
		ahb(1'b0, resb_pkg::ADDR_STATUS, 32'h0);
		chk("cipher off", {rd[5], cipher_active}, 2'h0);
		$display("test cipher done");
		results;
	end
	task results;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
endmodule // resb_core_test
